// >>> pkg/ipm_pkg.sv
// Shared constants, types and helpers of the interrupt and power-mode controller
package ipm_pkg;
  // Geometry
  localparam int NUM_SRC = 7;
  localparam int NUM_FLG = 9;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // Register offsets
  localparam logic [3:0] OFS_POWER = 4'h0;
  localparam logic [3:0] OFS_ENABLE = 4'h1;
  localparam logic [3:0] OFS_LVL_LO = 4'h2;
  localparam logic [3:0] OFS_LVL_HI = 4'h3;
  localparam logic [3:0] OFS_EXT_MODE = 4'h4;
  localparam logic [3:0] OFS_FLAGS = 4'h5;
  localparam logic [3:0] OFS_STATUS = 4'h6;
  // Power control field positions
  localparam int BIT_SLEEP = 0;
  localparam int BIT_PD = 1;
  // Status field positions
  localparam int STS_SVC_LSB = 0;
  localparam int STS_PM_LSB = 4;
  // Source indices in polling order
  localparam int SRC_EXT0 = 0;
  localparam int SRC_WDT = 1;
  localparam int SRC_CNT0 = 2;
  localparam int SRC_EXT1 = 3;
  localparam int SRC_CNT1 = 4;
  localparam int SRC_UART = 5;
  localparam int SRC_CNT2 = 6;
  // Hardware-cleared flags sit at their source index; the rest follow
  localparam int FLG_UART_TX = 5;
  localparam int FLG_UART_RX = 6;
  localparam int FLG_CNT2_OVF = 7;
  localparam int FLG_CNT2_TRIG = 8;
  localparam int NUM_HW_CLR = 5;
  // Vector addresses
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_WDT = 16'h0053;
  localparam logic [15:0] VEC_CNT0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_CNT1 = 16'h001B;
  localparam logic [15:0] VEC_UART = 16'h0023;
  localparam logic [15:0] VEC_CNT2 = 16'h002B;
  // Reset values
  localparam logic [1:0] RST_POWER = 2'h0;
  localparam logic [6:0] RST_ENABLE = 7'h00;
  localparam logic [6:0] RST_LVL = 7'h00;
  localparam logic [1:0] RST_EXT_MODE = 2'h0;
  localparam logic [8:0] RST_FLAGS = 9'h000;
  // Least low time of a waking pin, kept by the far side
  localparam int WAKE_LOW_CLK = 1024;

  // Power-mode sequencer states
  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_DOWN = 2'b01,
    PM_WAKE = 2'b10,
    PM_SERVE = 2'b11
  } ipm_pm_state_t;

  // Vector address of a source index
  function automatic logic [15:0] vec_of(input logic [2:0] idx);
    case (idx)
      3'h0: vec_of = VEC_EXT0;
      3'h1: vec_of = VEC_WDT;
      3'h2: vec_of = VEC_CNT0;
      3'h3: vec_of = VEC_EXT1;
      3'h4: vec_of = VEC_CNT1;
      3'h5: vec_of = VEC_UART;
      3'h6: vec_of = VEC_CNT2;
      default: vec_of = 16'h0000;
    endcase
  endfunction

  // Highest level in service: {valid, level}
  function automatic logic [2:0] top_level(input logic [3:0] svc);
    if (svc[3]) top_level = 3'h7;
    else if (svc[2]) top_level = 3'h6;
    else if (svc[1]) top_level = 3'h5;
    else if (svc[0]) top_level = 3'h4;
    else top_level = 3'h0;
  endfunction
endpackage

// >>> rtl/ipm_pin_sync.sv
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/100ps
module ipm_pin_sync (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_pin,
  output logic o_level
);
  // Stage chain; pins idle high
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // First stage is read by the second only
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end
    else
    begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only when stages two and three agree
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_level <= 1'b1;
    else if (s2_q == s3_q)
      o_level <= s3_q;
  end
endmodule // ipm_pin_sync

// >>> rtl/ipm_arbiter.sv
// Combinational level-and-order arbiter over the seven sources
`timescale 1ns/100ps
module ipm_arbiter (
  input wire logic [6:0] i_req,
  input wire logic [6:0] i_lvl_lo,
  input wire logic [6:0] i_lvl_hi,
  input wire logic i_floor_valid,
  input wire logic [1:0] i_floor_lvl,
  output logic o_valid,
  output logic [2:0] o_idx,
  output logic [1:0] o_lvl
);
  // Walk from last to first so that ties go to the earlier source
  always_comb
  begin
    logic [1:0] lvl;
    lvl = 2'h0;
    o_valid = 1'b0;
    o_idx = 3'h0;
    o_lvl = 2'h0;
    for (int i = ipm_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      lvl = {i_lvl_hi[i], i_lvl_lo[i]};
      // Only strictly higher than the running level may preempt
      if (i_req[i] && (!i_floor_valid || lvl > i_floor_lvl) && (!o_valid || lvl >= o_lvl))
      begin
        o_valid = 1'b1;
        o_idx = 3'(i);
        o_lvl = lvl;
      end
    end
  end
endmodule // ipm_arbiter

// >>> rtl/ipm_top.sv
// Interrupt arbitration and idle / power-down control for the small core
// What this block does
// - Seven sources, each one of four levels.
// - Fixed vectors; equal levels resolve by polling order.
// - Only level-mode external pins wake power-down.
// - Power control bit 0 enters idle.
// - Idle freezes PC; clock and interrupts run.
// - Idle leaves RAM and registers untouched.
// - Taken interrupt clears sleep bit, resumes after.
// - Hardware reset aborts modes like power-on.
// - Idle holds both strobes high.
// - Power control bit 1 enters power-down.
// - Power-down stops clock, keeps all contents.
// - Power-down drives both strobes low.
// - Only level external interrupt or reset exits.
// - Taking waking interrupt clears power-down bit.
// - After pin returns high, service then resume.
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
module ipm_top (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_ext_int0_n,
  input wire logic i_ext_int1_n,
  input wire logic i_wdt_evt,
  input wire logic i_cnt0_ovf,
  input wire logic i_cnt1_ovf,
  input wire logic i_cnt2_ovf,
  input wire logic i_cnt2_trig,
  input wire logic i_uart_tx_done,
  input wire logic i_uart_rx_done,
  input wire logic i_int_ack,
  input wire logic i_reti,
  input wire logic i_core_ale,
  input wire logic i_core_program_store_strobe_n_n,
  output logic [15:0] o_rdata,
  output logic o_int_req,
  output logic [15:0] o_vector,
  output logic o_pc_hold,
  output logic o_clk_stop,
  output logic o_ale,
  output logic o_program_store_strobe_n
);
  // Software-visible state
  logic sleep_request_bit_q;
  logic powerdown_request_bit_q;
  logic [6:0] enable_q; // Per-source enables in polling order
  logic [6:0] lvl_lo_q; // Low bit of each source level
  logic [6:0] lvl_hi_q; // High bit of each source level
  logic [1:0] ext_mode_q; // Set = edge mode, clear = level mode
  logic [8:0] flags_q; // Sticky event flags
  logic [3:0] in_svc_q; // One bit per level being serviced
  // Pin and arbitration signals
  logic ext0_lvl;
  logic ext1_lvl;
  logic ext0_prev_q;
  logic ext1_prev_q;
  logic ext_int0_pending;
  logic ext_int1_pending;
  logic [6:0] src_pend;
  logic [6:0] arb_req;
  logic arb_valid;
  logic [2:0] arb_idx;
  logic [1:0] arb_lvl;
  logic [2:0] floor;
  logic [2:0] cur_idx_q; // Source of the request on offer
  logic [1:0] cur_lvl_q; // Its level
  // Power-mode sequencer
  ipm_pkg::ipm_pm_state_t pm_q;
  logic [2:0] wake_idx_q; // External source that woke the part
  logic wake_lvl_now;
  logic wake_hit0;
  logic wake_hit1;
  logic wr_power;

  // Pins come from outside the clock domain
  ipm_pin_sync u_sync0 (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_pin(i_ext_int0_n),
    .o_level(ext0_lvl)
  );
  ipm_pin_sync u_sync1 (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_pin(i_ext_int1_n),
    .o_level(ext1_lvl)
  );

  // Previous filtered pin levels for falling-edge capture
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ext0_prev_q <= 1'b1;
      ext1_prev_q <= 1'b1;
    end
    else
    begin
      ext0_prev_q <= ext0_lvl;
      ext1_prev_q <= ext1_lvl;
    end
  end

  // event flags set
  // Set wins over both software and acknowledge clear
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    logic [8:0] set_v;
    logic [8:0] clr_v;
    if (!i_rstn)
      flags_q <= ipm_pkg::RST_FLAGS;
    else
    begin
      // Reset test stays first so the flops map onto async-reset cells
      set_v = '0;
      clr_v = '0;
      set_v[ipm_pkg::SRC_EXT0] = ext0_prev_q & ~ext0_lvl;
      set_v[ipm_pkg::SRC_WDT] = i_wdt_evt;
      set_v[ipm_pkg::SRC_CNT0] = i_cnt0_ovf;
      set_v[ipm_pkg::SRC_EXT1] = ext1_prev_q & ~ext1_lvl;
      set_v[ipm_pkg::SRC_CNT1] = i_cnt1_ovf;
      set_v[ipm_pkg::FLG_UART_TX] = i_uart_tx_done;
      set_v[ipm_pkg::FLG_UART_RX] = i_uart_rx_done;
      set_v[ipm_pkg::FLG_CNT2_OVF] = i_cnt2_ovf;
      set_v[ipm_pkg::FLG_CNT2_TRIG] = i_cnt2_trig;
      if (i_wr && i_addr == ipm_pkg::OFS_FLAGS)
        clr_v = i_wdata[8:0];
      // Vectoring clears the flags of sources with a single cause
      if (i_int_ack && int'(cur_idx_q) < ipm_pkg::NUM_HW_CLR)
        clr_v[cur_idx_q] = 1'b1;
      flags_q <= (flags_q & ~clr_v) | set_v;
    end
  end

  // combined pending
  // Uart and counter 2 each merge two causes
  assign ext_int0_pending = ext_mode_q[0] ? flags_q[ipm_pkg::SRC_EXT0] : ~ext0_lvl;
  assign ext_int1_pending = ext_mode_q[1] ? flags_q[ipm_pkg::SRC_EXT1] : ~ext1_lvl;
  assign src_pend = {flags_q[ipm_pkg::FLG_CNT2_OVF] | flags_q[ipm_pkg::FLG_CNT2_TRIG],
                     flags_q[ipm_pkg::FLG_UART_TX] | flags_q[ipm_pkg::FLG_UART_RX],
                     flags_q[ipm_pkg::SRC_CNT1], ext_int1_pending, flags_q[ipm_pkg::SRC_CNT0],
                     flags_q[ipm_pkg::SRC_WDT], ext_int0_pending};

  // power-down gating
  // Asleep nothing arbitrates; while serving the wake only that source does
  always_comb
  begin
    arb_req = '0;
    case (pm_q)
      ipm_pkg::PM_RUN: arb_req = src_pend & enable_q;
      ipm_pkg::PM_SERVE: arb_req[wake_idx_q] = 1'b1;
      default: arb_req = '0;
    endcase
  end

  assign floor = ipm_pkg::top_level(in_svc_q);

  ipm_arbiter u_arb (
    .i_req(arb_req),
    .i_lvl_lo(lvl_lo_q),
    .i_lvl_hi(lvl_hi_q),
    .i_floor_valid(floor[2]),
    .i_floor_lvl(floor[1:0]),
    .o_valid(arb_valid),
    .o_idx(arb_idx),
    .o_lvl(arb_lvl)
  );

  // vector on offer
  // Drop the request in the ack cycle so a stale winner is never offered twice
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_int_req <= 1'b0;
      o_vector <= 16'h0000;
      cur_idx_q <= 3'h0;
      cur_lvl_q <= 2'h0;
    end
    else
    begin
      o_int_req <= arb_valid & ~i_int_ack;
      o_vector <= ipm_pkg::vec_of(arb_idx);
      cur_idx_q <= arb_idx;
      cur_lvl_q <= arb_lvl;
    end
  end

  // nested service levels
  // Return retires the highest active level only
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    logic [3:0] nxt;
    if (!i_rstn)
      in_svc_q <= 4'h0;
    else
    begin
      nxt = in_svc_q;
      if (i_reti && floor[2])
        nxt[floor[1:0]] = 1'b0;
      if (i_int_ack && o_int_req)
        nxt[cur_lvl_q] = 1'b1;
      in_svc_q <= nxt;
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      enable_q <= ipm_pkg::RST_ENABLE;
      lvl_lo_q <= ipm_pkg::RST_LVL;
      lvl_hi_q <= ipm_pkg::RST_LVL;
      ext_mode_q <= ipm_pkg::RST_EXT_MODE;
    end
    else if (i_wr)
    begin
      case (i_addr)
        ipm_pkg::OFS_ENABLE: enable_q <= i_wdata[6:0];
        ipm_pkg::OFS_LVL_LO: lvl_lo_q <= i_wdata[6:0];
        ipm_pkg::OFS_LVL_HI: lvl_hi_q <= i_wdata[6:0];
        ipm_pkg::OFS_EXT_MODE: ext_mode_q <= i_wdata[1:0];
        default: ;
      endcase
    end
  end

  assign wr_power = i_wr && i_addr == ipm_pkg::OFS_POWER;

  // idle request bit
  // A write in the ack cycle wins, so a fresh idle request is kept
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      sleep_request_bit_q <= ipm_pkg::RST_POWER[ipm_pkg::BIT_SLEEP];
    else if (wr_power)
      sleep_request_bit_q <= i_wdata[ipm_pkg::BIT_SLEEP];
    else if (i_int_ack && o_int_req)
      sleep_request_bit_q <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      powerdown_request_bit_q <= ipm_pkg::RST_POWER[ipm_pkg::BIT_PD];
    else if (wr_power)
      powerdown_request_bit_q <= i_wdata[ipm_pkg::BIT_PD];
    else if (pm_q == ipm_pkg::PM_SERVE && i_int_ack && o_int_req)
      powerdown_request_bit_q <= 1'b0;
  end

  // Level-mode, enabled, pin held low
  assign wake_hit0 = ~ext_mode_q[0] & enable_q[ipm_pkg::SRC_EXT0] & ~ext0_lvl;
  assign wake_hit1 = ~ext_mode_q[1] & enable_q[ipm_pkg::SRC_EXT1] & ~ext1_lvl;
  assign wake_lvl_now = (wake_idx_q == 3'(ipm_pkg::SRC_EXT0)) ? ext0_lvl : ext1_lvl;

  // power-down sequencer
  // Only a level-mode pin leaves DOWN; reset is the other exit
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pm_q <= ipm_pkg::PM_RUN;
      wake_idx_q <= 3'h0;
    end
    else
    begin
      case (pm_q)
        ipm_pkg::PM_RUN:
          if (powerdown_request_bit_q)
            pm_q <= ipm_pkg::PM_DOWN;
        ipm_pkg::PM_DOWN:
          // Pin 0 wins when both pins wake together
          if (wake_hit0 || wake_hit1)
          begin
            pm_q <= ipm_pkg::PM_WAKE;
            wake_idx_q <= wake_hit0 ? 3'(ipm_pkg::SRC_EXT0) : 3'(ipm_pkg::SRC_EXT1);
          end
        // wait for pin release
        // Low time is the far side's duty; the oscillator restarts meanwhile
        ipm_pkg::PM_WAKE:
          if (wake_lvl_now)
            pm_q <= ipm_pkg::PM_SERVE;
        ipm_pkg::PM_SERVE:
          if (i_int_ack && o_int_req)
            pm_q <= ipm_pkg::PM_RUN;
        default: pm_q <= ipm_pkg::PM_RUN;
      endcase
    end
  end

  // nothing here writes core state while halted
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_pc_hold <= 1'b0;
      o_clk_stop <= 1'b0;
    end
    else
    begin
      o_pc_hold <= sleep_request_bit_q | powerdown_request_bit_q;
      o_clk_stop <= pm_q == ipm_pkg::PM_DOWN;
    end
  end

  // strobes low when down
  // High at reset, as the core expects during its own reset
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_ale <= 1'b1;
      o_program_store_strobe_n <= 1'b1;
    end
    else if (pm_q == ipm_pkg::PM_DOWN || pm_q == ipm_pkg::PM_WAKE)
    begin
      o_ale <= 1'b0;
      o_program_store_strobe_n <= 1'b0;
    end
    else if (sleep_request_bit_q || powerdown_request_bit_q)
    begin
      o_ale <= 1'b1;
      o_program_store_strobe_n <= 1'b1;
    end
    else
    begin
      o_ale <= i_core_ale;
      o_program_store_strobe_n <= i_core_program_store_strobe_n_n;
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= 16'h0000;
    else if (!i_rd)
      o_rdata <= 16'h0000;
    else
    begin
      case (i_addr)
        ipm_pkg::OFS_POWER: o_rdata <= {14'h0000, powerdown_request_bit_q, sleep_request_bit_q};
        ipm_pkg::OFS_ENABLE: o_rdata <= {9'h000, enable_q};
        ipm_pkg::OFS_LVL_LO: o_rdata <= {9'h000, lvl_lo_q};
        ipm_pkg::OFS_LVL_HI: o_rdata <= {9'h000, lvl_hi_q};
        ipm_pkg::OFS_EXT_MODE: o_rdata <= {14'h0000, ext_mode_q};
        ipm_pkg::OFS_FLAGS: o_rdata <= {7'h00, flags_q};
        ipm_pkg::OFS_STATUS: o_rdata <= {10'h000, pm_q, in_svc_q};
        default: o_rdata <= 16'h0000;
      endcase
    end
  end

  // Steps of the power-down entry and the wake
  sequence s_pd_enter;
    powerdown_request_bit_q ##1 (pm_q == ipm_pkg::PM_DOWN);
  endsequence
  sequence s_wake_serve;
    (pm_q == ipm_pkg::PM_SERVE) ##[1:3] o_int_req;
  endsequence

  property p_vector_map;
    @(posedge i_clk) disable iff (!i_rstn) o_int_req |-> o_vector == ipm_pkg::vec_of(cur_idx_q);
  endproperty
  a_vector_map: assert property (p_vector_map) else $error("vector does not match source");
  property p_enabled_only;
    @(posedge i_clk) disable iff (!i_rstn)
      (o_int_req && pm_q == ipm_pkg::PM_RUN && $past(pm_q) == ipm_pkg::PM_RUN) |-> enable_q[cur_idx_q];
  endproperty
  a_enabled_only: assert property (p_enabled_only) else $error("disabled source requested");
  property p_down_quiet;
    @(posedge i_clk) disable iff (!i_rstn) (pm_q == ipm_pkg::PM_DOWN) |=> !o_int_req;
  endproperty
  a_down_quiet: assert property (p_down_quiet) else $error("request while powered down");
  property p_pd_enter;
    @(posedge i_clk) disable iff (!i_rstn)
      (wr_power && i_wdata[ipm_pkg::BIT_PD] && pm_q == ipm_pkg::PM_RUN) |=> s_pd_enter;
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");
  property p_down_strobes;
    @(posedge i_clk) disable iff (!i_rstn)
      (pm_q == ipm_pkg::PM_DOWN) |=> (!o_ale && !o_program_store_strobe_n && o_clk_stop);
  endproperty
  a_down_strobes: assert property (p_down_strobes) else $error("strobes or clock wrong when down");
  property p_idle_strobes;
    @(posedge i_clk) disable iff (!i_rstn)
      (sleep_request_bit_q && pm_q == ipm_pkg::PM_RUN) |=> (o_ale && o_program_store_strobe_n && o_pc_hold);
  endproperty
  a_idle_strobes: assert property (p_idle_strobes) else $error("idle strobes not high");
  property p_idle_exit;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_int_ack && o_int_req && sleep_request_bit_q && !wr_power) |=> !sleep_request_bit_q;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("sleep bit kept after vectoring");
  property p_wake_serve;
    @(posedge i_clk) disable iff (!i_rstn) (pm_q == ipm_pkg::PM_WAKE && wake_lvl_now) |=> s_wake_serve;
  endproperty
  a_wake_serve: assert property (p_wake_serve) else $error("no wake service after release");
  property p_down_exit;
    @(posedge i_clk) disable iff (!i_rstn)
      (pm_q == ipm_pkg::PM_DOWN && !wake_hit0 && !wake_hit1) |=> pm_q == ipm_pkg::PM_DOWN;
  endproperty
  a_down_exit: assert property (p_down_exit) else $error("power-down left without a wake");
endmodule // ipm_top

// >>> tb/ipm_far_model.sv
// Far-side model: external interrupt pins and peripheral event lines
`timescale 1ns/100ps
module ipm_far_model #(
  parameter int LOW_MIN = ipm_pkg::WAKE_LOW_CLK
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_go,
  input wire logic [3:0] i_sel,
  output logic o_busy,
  output logic o_ext0_n,
  output logic o_ext1_n,
  output logic [8:0] o_evt
);
  // Remaining cycles of the current action
  logic [15:0] cnt_q;
  // Selected line, flag numbering
  logic [3:0] sel_q;

  // Pins stay low the full wake time; events last one cycle
  // hold pin low
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_q <= 16'h0000;
      sel_q <= 4'h0;
    end
    else if (i_go && cnt_q == 16'h0000)
    begin
      sel_q <= i_sel;
      cnt_q <= (i_sel == 4'h0 || i_sel == 4'h3) ? 16'(LOW_MIN) : 16'h0001;
    end
    else if (cnt_q != 16'h0000)
      cnt_q <= cnt_q - 16'h0001;
  end

  assign o_busy = (cnt_q != 16'h0000);
  // Released pins return to the pull-up level
  assign o_ext0_n = !(o_busy && sel_q == 4'h0);
  assign o_ext1_n = !(o_busy && sel_q == 4'h3);
  // Pin positions are masked out of the event lines
  assign o_evt = o_busy ? ((9'h001 << sel_q) & 9'h1F6) : 9'h000;
endmodule // ipm_far_model

// >>> tb/testbench.sv
// Self-checking bench of the interrupt and power-mode controller
`timescale 1ns/100ps
module testbench;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic ack = 1'b0;
  logic reti = 1'b0;
  logic core_ale = 1'b0;
  logic core_program_store_strobe_n_n = 1'b0;
  logic go = 1'b0;
  logic [3:0] sel = 4'h0;
  logic busy, ext0_n, ext1_n;
  logic [8:0] evt;
  logic [15:0] rdata, vector;
  logic int_req, pc_hold, clk_stop, ale, program_store_strobe_n_n;
  int failures = 0;
  int comparisons = 0;
  // Expected vector per flag number
  logic [15:0] vtab [9] = '{16'h0003, 16'h0053, 16'h000B, 16'h0013, 16'h001B,
                            16'h0023, 16'h0023, 16'h002B, 16'h002B};

  initial
  begin
    forever #10 i_clk = ~i_clk;
  end

  ipm_far_model u_ipm_far_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_go(go), .i_sel(sel), .o_busy(busy),
    .o_ext0_n(ext0_n), .o_ext1_n(ext1_n), .o_evt(evt));

  ipm_top u_ipm_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
    .i_rd(rd_s), .i_ext_int0_n(ext0_n), .i_ext_int1_n(ext1_n), .i_wdt_evt(evt[1]), .i_cnt0_ovf(evt[2]),
    .i_cnt1_ovf(evt[4]), .i_cnt2_ovf(evt[7]), .i_cnt2_trig(evt[8]), .i_uart_tx_done(evt[5]),
    .i_uart_rx_done(evt[6]), .i_int_ack(ack), .i_reti(reti), .i_core_ale(core_ale),
    .i_core_program_store_strobe_n_n(core_program_store_strobe_n_n), .o_rdata(rdata), .o_int_req(int_req), .o_vector(vector),
    .o_pc_hold(pc_hold), .o_clk_stop(clk_stop), .o_ale(ale), .o_program_store_strobe_n(program_store_strobe_n_n));

  // Verdict and end of run
  task automatic test_done();
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge i_clk);
    wr_s <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge i_clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic pulse(input int w);
    @(posedge i_clk);
    if (w == 0) ack <= 1'b1;
    else reti <= 1'b1;
    @(posedge i_clk);
    ack <= 1'b0;
    reti <= 1'b0;
  endtask

  // Bounded wait: 0 request, 1 clock stop, 2 far side busy
  task automatic wait_lvl(input int w, input logic v, input int lim);
    logic s;
    s = ~v;
    for (int n = 0; n < lim && s !== v; n++)
    begin
      @(posedge i_clk);
      #1;
      s = (w == 0) ? int_req : (w == 1) ? clk_stop : busy;
    end
    if (s !== v)
    begin
      chk(16'(s), 16'(v));
      test_done();
    end
  endtask

  task automatic fire(input logic [3:0] s, input bit hold);
    @(posedge i_clk);
    go <= 1'b1;
    sel <= s;
    @(posedge i_clk);
    go <= 1'b0;
    if (hold) wait_lvl(2, 1'b0, 1100);
  endtask

  task automatic take(input logic [15:0] exp);
    wait_lvl(0, 1'b1, 40);
    chk(vector, exp);
    pulse(0);
  endtask

  // Software-cleared flags are cleared before the return
  task automatic serve(input logic [15:0] exp, input int f);
    take(exp);
    if (f >= 5) wr(ipm_pkg::OFS_FLAGS, 16'h0001 << f);
    pulse(1);
  endtask

  initial
  begin
    // Outputs are unknown until the first edge applies the reset
    @(posedge i_clk);
    #1;
    chk(16'({ale, program_store_strobe_n_n, clk_stop, int_req}), 16'h000C);
    repeat (9) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int a = 0; a < 7; a++) rd_chk(4'(a), 16'h0000);
    rd_chk(4'hF, 16'h0000);
    // Every flag through its vector, pins in edge mode
    wr(ipm_pkg::OFS_EXT_MODE, 16'h0003);
    wr(ipm_pkg::OFS_ENABLE, 16'h007F);
    for (int f = 0; f < 9; f++)
    begin
      fire(4'(f), 1'b1);
      serve(vtab[f], f);
    end
    // Disabled pending flags, then ties by polling order
    wr(ipm_pkg::OFS_ENABLE, 16'h0000);
    fire(4'h8, 1'b1);
    fire(4'h4, 1'b1);
    fire(4'h1, 1'b1);
    repeat (4) @(posedge i_clk);
    #1;
    chk(16'(int_req), 16'h0000);
    wr(ipm_pkg::OFS_ENABLE, 16'h007F);
    serve(16'h0053, 1);
    serve(16'h001B, 4);
    serve(16'h002B, 8);
    // Counter 2 at level 3 preempts level 0 service
    wr(ipm_pkg::OFS_LVL_LO, 16'h0040);
    wr(ipm_pkg::OFS_LVL_HI, 16'h0040);
    fire(4'h2, 1'b1);
    take(16'h000B);
    fire(4'h4, 1'b1);
    repeat (4) @(posedge i_clk);
    #1;
    chk(16'(int_req), 16'h0000);
    fire(4'h7, 1'b1);
    take(16'h002B);
    rd_chk(ipm_pkg::OFS_STATUS, 16'h0009);
    wr(ipm_pkg::OFS_FLAGS, 16'h0080);
    pulse(1);
    pulse(1);
    serve(16'h001B, 4);
    // Idle entry, strobes high, exit by interrupt
    wr(ipm_pkg::OFS_POWER, 16'h0001);
    rd_chk(ipm_pkg::OFS_POWER, 16'h0001);
    chk(16'({pc_hold, ale, program_store_strobe_n_n}), 16'h0007);
    rd_chk(ipm_pkg::OFS_ENABLE, 16'h007F);
    fire(4'h2, 1'b1);
    serve(16'h000B, 2);
    rd_chk(ipm_pkg::OFS_POWER, 16'h0000);
    chk(16'({pc_hold, ale, program_store_strobe_n_n}), 16'h0000);
    // Power-down; only a level pin wakes it
    wr(ipm_pkg::OFS_EXT_MODE, 16'h0000);
    core_ale <= 1'b1;
    core_program_store_strobe_n_n <= 1'b1;
    wr(ipm_pkg::OFS_POWER, 16'h0002);
    wait_lvl(1, 1'b1, 10);
    chk(16'({pc_hold, ale, program_store_strobe_n_n}), 16'h0004);
    fire(4'h2, 1'b1);
    fire(4'h1, 1'b1);
    repeat (5) @(posedge i_clk);
    #1;
    chk(16'({clk_stop, int_req}), 16'h0002);
    fire(4'h0, 1'b0);
    wait_lvl(1, 1'b0, 20);
    chk(16'(int_req), 16'h0000);
    wait_lvl(2, 1'b0, 1100);
    take(16'h0003);
    rd_chk(ipm_pkg::OFS_POWER, 16'h0000);
    chk(16'({pc_hold, ale, program_store_strobe_n_n}), 16'h0003);
    wr(ipm_pkg::OFS_FLAGS, 16'h01FF);
    pulse(1);
    // Hardware reset while powered down
    wr(ipm_pkg::OFS_POWER, 16'h0002);
    wait_lvl(1, 1'b1, 10);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    #1;
    chk(16'({ale, program_store_strobe_n_n, clk_stop, pc_hold}), 16'h000C);
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd_chk(ipm_pkg::OFS_POWER, 16'h0000);
    rd_chk(ipm_pkg::OFS_ENABLE, 16'h0000);
    test_done();
  end
endmodule // testbench
